// file: hdl/bsg_params.svh
// Constants for the boot-stage input gate and completer
`ifndef BSG_PARAMS_SVH
`define BSG_PARAMS_SVH

// **********************************************************
// Handshake and sizing
// **********************************************************
`define BSG_PAT_A        8'h12
`define BSG_PAT_B        8'h9A
`define BSG_COUNTDOWN    16'h0040
`define BSG_FIFO_DEPTH   4
`define BSG_COMPLETER_ID 16'h0000

// **********************************************************
// Request header fields (first and second header words) and word positions
// **********************************************************
`define BSG_FMT_HI       31
`define BSG_FMT_LO       29
`define BSG_TYPE_HI      28
`define BSG_TYPE_LO      24
`define BSG_FMT_DATA     1
`define BSG_FMT_4DW      0
`define BSG_TYPE_MEM     5'h00
`define BSG_TYPE_IO      5'h02
`define BSG_TAG_LO       8
`define BSG_WC_ADDR3     3'h2
`define BSG_WC_ADDR4     3'h3
`define BSG_WC_HDR3      3'h3
`define BSG_WC_HDR4      3'h4
`define BSG_WC_MAX       3'h4

// **********************************************************
// Completion words
// **********************************************************
`define BSG_CPL_DW0      32'h4A000001
`define BSG_CPL_STATUS   4'h0
`define BSG_CPL_BCOUNT   12'h004
`define BSG_CPL_DATA     32'h00000000
`define BSG_CPL_LAST_IDX 2'h3

`endif

// file: hdl/bsg_pkg.sv
// Types shared by the boot-stage gate, completer and bench
package bsg_pkg;

    // One stream word with its end-of-packet mark
    typedef struct packed {
        logic        last;
        logic [31:0] data;
    } bsg_word_type;

    // Critical core inputs held low until the second stage is up
    typedef struct packed {
        logic cfgMgmtRead;
        logic cfgMgmtWrite;
        logic cfgIntReq;
        logic cfgPowerReq;
        logic cfgErrReport;
    } bsg_crit_type;

    // Completer states
    typedef enum logic [1:0] {
        CMP_RECV = 2'b01,
        CMP_EMIT = 2'b10
    } bsg_cmp_state_type;

endpackage

// file: hdl/bsg_fifo.sv
// Small register FIFO with registered flags
`timescale 1ns/1ps
`default_nettype none

module bsg_fifo #(
    parameter int unsigned WIDTH = 33,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Filling side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Draining side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    wire logic        wrFire;
    wire logic        rdFire;

    // **********************************************************
    // Handshakes
    // **********************************************************
    assign wrFire  = inValid && inReady;
    assign rdFire  = outValid && outReady;
    assign outData = mem[rdPtr_q];
    assign cnt_d   = cnt_q + CW'(wrFire) - CW'(rdFire);

    // Storage has no reset; only valid entries are ever read
    always_ff @(posedge clk) begin
        if (wrFire) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Flags come from the next count, so they are exact; pointers step on each fire
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_q  <= '0;
            rdPtr_q  <= '0;
            cnt_q    <= '0;
            inReady  <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (wrFire) begin
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
            end
            if (rdFire) begin
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
            end
            cnt_q    <= cnt_d;
            inReady  <= cnt_d < FULL_CNT;
            outValid <= cnt_d != '0;
        end
    end

endmodule

`default_nettype wire

// file: hdl/bsg_gate_completer.sv
// First-stage boot logic: critical input gate and minimal completer
`timescale 1ns/1ps
`default_nettype none
`include "bsg_params.svh"

module bsg_gate_completer #(
    parameter int unsigned FIFO_DEPTH   = `BSG_FIFO_DEPTH,
    parameter logic [7:0]  PAT_A        = `BSG_PAT_A,
    parameter logic [7:0]  PAT_B        = `BSG_PAT_B,
    parameter logic [15:0] COUNTDOWN    = `BSG_COUNTDOWN,
    parameter logic [15:0] COMPLETER_ID = `BSG_COMPLETER_ID // arbitrary
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Second-stage handshake
    input  wire logic [7:0]            stage2Pattern,
    output logic                       stage2Ready,
    // Critical inputs, user side and core side
    input  wire bsg_pkg::bsg_crit_type userCrit,
    output bsg_pkg::bsg_crit_type      coreCrit,
    // Requests received from the core
    input  wire bsg_pkg::bsg_word_type coreRxWord,
    input  wire logic                  coreRxValid,
    output logic                       coreRxReady,
    // Requests passed on to the user
    output bsg_pkg::bsg_word_type      userRxWord,
    output logic                       userRxValid,
    input  wire logic                  userRxReady,
    // Transmit words from the user
    input  wire bsg_pkg::bsg_word_type userTxWord,
    input  wire logic                  userTxValid,
    output logic                       userTxReady,
    // Transmit words to the core
    output bsg_pkg::bsg_word_type      coreTxWord,
    output logic                       coreTxValid,
    input  wire logic                  coreTxReady,
    // Internal configuration access port
    output logic [31:0]                cfgPortData,
    output logic                       cfgPortWrite
);
    import bsg_pkg::*;

    localparam int unsigned WW = $bits(bsg_word_type);

    // **********************************************************
    // Second-stage ready detector
    // **********************************************************
    logic [7:0]  patPrev_q;
    logic [15:0] down_q;
    logic        patGood_q;
    wire logic   patGood;

    // A pair of consecutive samples must be A then B or B then A
    assign patGood = (stage2Pattern == PAT_A && patPrev_q == PAT_B) ||
                     (stage2Pattern == PAT_B && patPrev_q == PAT_A);

    // Any break in the pattern restarts the countdown from the top
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            patPrev_q   <= 8'h00;
            patGood_q   <= 1'b0;
            down_q      <= COUNTDOWN;
            stage2Ready <= 1'b0;
        end else begin
            patPrev_q <= stage2Pattern;
            patGood_q <= patGood;
            if (!patGood) begin
                down_q <= COUNTDOWN;
            end else if (down_q != 16'h0000) begin
                down_q <= down_q - 16'h0001;
            end
            if (patGood && down_q == 16'h0001) begin
                stage2Ready <= 1'b1;
            end
        end
    end

    // **********************************************************
    // Critical input muxes
    // **********************************************************
    // Held low while undriven second-stage nets may glitch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coreCrit <= '0;
        end else begin
            coreCrit <= stage2Ready ? userCrit : '0;
        end
    end

    // **********************************************************
    // Receive holding register, shared by completer and user
    // **********************************************************
    bsg_cmp_state_type state_q;
    bsg_cmp_state_type state_d;
    logic              ownerUser_q;
    logic              holdValid_q;
    logic              holdValid_d;
    logic [2:0]        wc_q;
    logic              isRd_q;
    logic              isWr_q;
    logic              hdr4_q;
    logic [23:0]       reqTag_q;
    logic [6:0]        lowAddr_q;
    logic [1:0]        emitIdx_q;
    wire logic         take;
    wire logic         cmpTake;
    wire logic         consume;
    wire logic         handoff;
    wire logic         rdNow;
    wire logic         wrNow;
    wire logic         dataWord;
    wire logic [2:0]   fmt;
    wire logic [4:0]   tlpType;

    assign take     = coreRxValid && coreRxReady;
    assign cmpTake  = holdValid_q && !ownerUser_q && state_q == CMP_RECV;
    assign consume  = ownerUser_q ? (holdValid_q && userRxReady) : cmpTake;
    assign handoff  = stage2Ready && state_q == CMP_RECV && wc_q == 3'h0;
    assign fmt      = userRxWord.data[`BSG_FMT_HI:`BSG_FMT_LO];
    assign tlpType  = userRxWord.data[`BSG_TYPE_HI:`BSG_TYPE_LO];
    assign rdNow    = (wc_q == 3'h0) ? (!fmt[`BSG_FMT_DATA] &&
                      (tlpType == `BSG_TYPE_MEM || tlpType == `BSG_TYPE_IO))
                      : isRd_q;
    assign wrNow    = fmt[`BSG_FMT_DATA] && tlpType == `BSG_TYPE_MEM;
    assign dataWord = isWr_q &&
                      wc_q >= (hdr4_q ? `BSG_WC_HDR4 : `BSG_WC_HDR3);
    // Ready to the core only while the holder will be empty: half rate,
    // but no word is ever dropped by a registered ready
    assign holdValid_d = take ? 1'b1 : (consume ? 1'b0 : holdValid_q);

    // Holder and the user-facing copies of its state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            holdValid_q <= 1'b0;
            coreRxReady <= 1'b0;
            userRxValid <= 1'b0;
            userRxWord  <= '0;
            ownerUser_q <= 1'b0;
        end else begin
            holdValid_q <= holdValid_d;
            coreRxReady <= !holdValid_d;
            userRxValid <= holdValid_d && (ownerUser_q || handoff);
            if (take) begin
                userRxWord <= coreRxWord;
            end
            if (handoff) begin
                ownerUser_q <= 1'b1;
            end
        end
    end

    // **********************************************************
    // First-stage completer
    // **********************************************************
    wire logic         fifoInReady;
    wire logic         push;
    bsg_word_type      cplWord;

    assign push = state_q == CMP_EMIT;
    // Completion: header, success status, echoed ID and tag, zero data
    assign cplWord.last = emitIdx_q == `BSG_CPL_LAST_IDX;
    assign cplWord.data =
        (emitIdx_q == 2'h0) ? `BSG_CPL_DW0 :
        (emitIdx_q == 2'h1) ? {COMPLETER_ID, `BSG_CPL_STATUS,
                               `BSG_CPL_BCOUNT} :
        (emitIdx_q == 2'h2) ? {reqTag_q, 1'b0, lowAddr_q} :
                              `BSG_CPL_DATA;

    // Reads go to EMIT at their last word; all else stays in RECV and gets no completion
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CMP_RECV: begin
                if (cmpTake && userRxWord.last && rdNow) begin
                    state_d = CMP_EMIT;
                end
            end
            CMP_EMIT: begin
                if (fifoInReady && emitIdx_q == `BSG_CPL_LAST_IDX) begin
                    state_d = CMP_RECV;
                end
            end
            default: state_d = CMP_RECV;
        endcase
    end

    // Header capture, word count and config-port writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q      <= CMP_RECV;
            wc_q         <= 3'h0;
            isRd_q       <= 1'b0;
            isWr_q       <= 1'b0;
            hdr4_q       <= 1'b0;
            reqTag_q     <= '0;
            lowAddr_q    <= '0;
            emitIdx_q    <= 2'h0;
            cfgPortData  <= '0;
            cfgPortWrite <= 1'b0;
        end else begin
            state_q      <= state_d;
            cfgPortWrite <= cmpTake && dataWord;
            if (cmpTake) begin
                if (wc_q == 3'h0) begin
                    isRd_q <= rdNow;
                    isWr_q <= wrNow;
                    hdr4_q <= fmt[`BSG_FMT_4DW];
                end
                if (wc_q == 3'h1) begin
                    reqTag_q <= userRxWord.data[31:`BSG_TAG_LO];
                end
                if (wc_q == (hdr4_q ? `BSG_WC_ADDR4 : `BSG_WC_ADDR3)) begin
                    lowAddr_q <= userRxWord.data[6:0];
                end
                if (dataWord) begin
                    cfgPortData <= userRxWord.data;
                end
                wc_q <= userRxWord.last ? 3'h0 :
                        (wc_q == `BSG_WC_MAX ? wc_q : wc_q + 3'h1);
            end
            if (push && fifoInReady) begin
                emitIdx_q <= emitIdx_q + 2'h1;
            end
        end
    end

    // **********************************************************
    // Transmit FIFO and output stage
    // **********************************************************
    bsg_word_type fifoInWord;
    bsg_word_type fifoOutWord;
    wire logic    fifoInValid;
    wire logic    fifoOutValid;
    wire logic    pop;

    // User transmit is ignored until handoff, like the gated inputs
    assign fifoInValid = ownerUser_q ? userTxValid : push;
    assign fifoInWord  = ownerUser_q ? userTxWord : cplWord;
    assign userTxReady = fifoInReady;
    assign pop         = fifoOutValid && (!coreTxValid || coreTxReady);

    bsg_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) txFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .inData   (fifoInWord),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .outData  (fifoOutWord),
        .outValid (fifoOutValid),
        .outReady (pop)
    );

    // Output register stage keeps the core side driven by flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coreTxValid <= 1'b0;
            coreTxWord  <= '0;
        end else begin
            if (pop) begin
                coreTxValid <= 1'b1;
                coreTxWord  <= fifoOutWord;
            end else if (coreTxReady) begin
                coreTxValid <= 1'b0;
            end
        end
    end

    // **********************************************************
    // Checks
    // **********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_gate_low: assert property (!stage2Ready |=> coreCrit == '0)
        else $error("critical input passed before ready");
    chk_gate_pass: assert property (
        stage2Ready |=> coreCrit == $past(userCrit))
        else $error("critical input not passed after ready");
    chk_ready_sticky: assert property (
        stage2Ready |=> stage2Ready)
        else $error("ready dropped");
    chk_ready_count: assert property (
        $rose(stage2Ready) |-> $past(patGood) && $past(down_q) == 16'h0001)
        else $error("ready without finished countdown");
    chk_rx_drain: assert property (
        cmpTake |=> !holdValid_q)
        else $error("completer stalled the receive path");
    chk_cpl_zero: assert property (
        push && emitIdx_q == 2'h3 |-> fifoInValid && cplWord.data == '0
        && cplWord.last)
        else $error("completion data not zero");
    chk_cpl_tag: assert property (
        push && emitIdx_q == 2'h2 |-> fifoInWord.data[31:8] == reqTag_q)
        else $error("completion lost requester tag");
    chk_drop_silent: assert property (
        cmpTake && userRxWord.last && !rdNow |=> state_q == CMP_RECV)
        else $error("non-read produced output");
    chk_user_quiet: assert property (
        !ownerUser_q |-> !userRxValid)
        else $error("user saw requests in first stage");
    chk_cfg_write: assert property (
        cfgPortWrite |-> $past(cmpTake) && $past(isWr_q))
        else $error("config port written without write data");
    chk_handoff: assert property (
        $rose(ownerUser_q) |-> $past(stage2Ready) && $past(wc_q) == 3'h0)
        else $error("handoff inside a packet");

    cov_ready: cover property ($rose(stage2Ready));
    cov_cpl: cover property (push && fifoInReady && emitIdx_q == 2'h3);
    cov_cfg: cover property (cfgPortWrite);
    cov_user: cover property (ownerUser_q && userRxValid && userRxReady);

endmodule

`default_nettype wire

// file: testbench/bsg_far_model.sv
// Far-side model: second-stage pattern source and core transmit sink
`timescale 1ns/1ps
`default_nettype none
`include "bsg_params.svh"

module bsg_far_model (
    // Clock
    input  wire logic       clk,
    // Controls from the bench
    input  wire logic [1:0] patMode,
    input  wire logic       stall,
    input  wire logic       coin,
    // Far-side outputs
    output logic [7:0]      pattern,
    output logic            txReady
);
    logic phase;

    initial begin
        pattern = 8'h00;
        txReady = 1'b0;
        phase   = 1'b0;
    end

    // Pattern source; an unloaded stage toggles junk, never a good pair
    always @(negedge clk) begin
        phase <= ~phase;
        case (patMode)
            2'd1: pattern <= phase ? `BSG_PAT_A : `BSG_PAT_B;
            2'd2: pattern <= `BSG_PAT_A; // Stuck source
            default: pattern <= ~pattern;
        endcase
        txReady <= ~stall & coin; // Random back-pressure
    end
endmodule
`default_nettype wire

// file: testbench/bsg_gate_completer_tb.sv
// Self-checking bench for the boot-stage gate and completer
`timescale 1ns/1ps
`default_nettype none
`include "bsg_params.svh"

module bsg_gate_completer_tb;
    import bsg_pkg::*;
    localparam int CNT = 4; // Short countdown keeps the run brief

    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    logic [7:0]   stage2Pattern;
    logic         stage2Ready, coreRxValid, coreRxReady, userRxValid;
    logic         userRxReady, userTxValid, userTxReady, coreTxValid;
    logic         coreTxReady, cfgPortWrite, stall, coin;
    logic         rdyPrev = 1'b0;
    logic [1:0]   patMode;
    logic [31:0]  cfgPortData;
    logic [31:0]  seed = 32'h00005B71;
    bsg_crit_type userCrit, coreCrit;
    bsg_word_type coreRxWord, userRxWord, userTxWord, coreTxWord;
    bsg_word_type txQ[$];
    bsg_word_type rxQ[$];
    logic [31:0]  cfgQ[$];
    int           mismatches = 0;
    int           compares = 0;
    int           cycles = 0;

    bsg_gate_completer #(.COUNTDOWN(16'h0004)) u_dut (
        .clk(clk), .reset_n(reset_n),
        .stage2Pattern(stage2Pattern), .stage2Ready(stage2Ready),
        .userCrit(userCrit), .coreCrit(coreCrit),
        .coreRxWord(coreRxWord), .coreRxValid(coreRxValid),
        .coreRxReady(coreRxReady),
        .userRxWord(userRxWord), .userRxValid(userRxValid),
        .userRxReady(userRxReady),
        .userTxWord(userTxWord), .userTxValid(userTxValid),
        .userTxReady(userTxReady),
        .coreTxWord(coreTxWord), .coreTxValid(coreTxValid),
        .coreTxReady(coreTxReady),
        .cfgPortData(cfgPortData), .cfgPortWrite(cfgPortWrite)
    );

    bsg_far_model u_far (
        .clk(clk), .patMode(patMode), .stall(stall), .coin(coin),
        .pattern(stage2Pattern), .txReady(coreTxReady)
    );

    always #12.5 clk = ~clk;

    // **********************************************************
    // Helpers
    // **********************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Sends one packet; each word is held until its ready is seen high
    task automatic send(input bit toUser, input logic [31:0] w[$]);
        for (int i = 0; i < w.size(); i++) begin
            @(negedge clk);
            if (toUser) begin
                userTxWord  <= {i == w.size() - 1, w[i]};
                userTxValid <= 1'b1;
            end else begin
                coreRxWord  <= {i == w.size() - 1, w[i]};
                coreRxValid <= 1'b1;
            end
            while ((toUser ? userTxReady : coreRxReady) !== 1'b1)
                @(negedge clk);
            @(posedge clk);
        end
        @(negedge clk);
        userTxValid <= 1'b0;
        coreRxValid <= 1'b0;
    endtask

    // Completion words follow from the request's header fields
    task automatic expect_cpl(input logic [31:0] dw1, input logic [31:0] ad);
        bsg_word_type exp[4];
        exp[0] = {1'b0, `BSG_CPL_DW0};
        exp[1] = {1'b0, `BSG_COMPLETER_ID, `BSG_CPL_STATUS, `BSG_CPL_BCOUNT};
        exp[2] = {1'b0, dw1[31:8], 1'b0, ad[6:0]};
        exp[3] = {1'b1, `BSG_CPL_DATA};
        for (int t = 0; t < 200 && txQ.size() < 4; t++) @(negedge clk);
        check(txQ.size(), 4);
        for (int i = 0; i < 4 && txQ.size() > 0; i++)
            check(txQ.pop_front(), exp[i]);
    endtask

    // **********************************************************
    // Monitors, random drive and timeout
    // **********************************************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (coreTxValid && coreTxReady) txQ.push_back(coreTxWord);
        if (userRxValid && userRxReady) rxQ.push_back(userRxWord);
        if (cfgPortWrite) cfgQ.push_back(cfgPortData);
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // Gate opens one cycle after ready, since the mux output is registered
    always @(negedge clk) begin
        if (reset_n && rdyPrev !== 1'b1) check(coreCrit, 0);
        if (reset_n && rdyPrev === 1'b1) check(coreCrit, userCrit);
        rdyPrev     <= stage2Ready;
        userCrit    <= bsg_crit_type'(rnd());
        userRxReady <= rnd() % 4 != 0;
        coin        <= rnd() % 3 != 0;
    end

    // **********************************************************
    // Main sequence
    // **********************************************************
    initial begin
        logic [31:0] dw1, ad, hdr;
        int n;
        {coreRxValid, userTxValid, stall, coin, userRxReady} = '0;
        {coreRxWord, userTxWord, userCrit} = '0;
        patMode = 2'd0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        // Reads of every kind, one with a longer length field
        for (int k = 0; k < 3; k++) begin
            dw1 = rnd();
            ad  = rnd();
            hdr = k == 1 ? 32'h20000001 :
                  (k == 2 ? 32'h02000001 : 32'h00000008);
            if (k == 1) send(0, '{hdr, dw1, rnd(), ad});
            else send(0, '{hdr, dw1, ad});
            expect_cpl(dw1, ad);
            $display("read test %0d done", k);
        end
        // Messages and IO write vanish; user transmit, driven during the first message, is ignored
        userTxValid <= 1'b1;
        userTxWord  <= {1'b1, rnd()};
        send(0, '{32'h34000000, rnd(), rnd(), rnd()});
        send(0, '{32'h70000001, rnd(), rnd(), rnd(), rnd()});
        send(0, '{32'h42000001, rnd(), rnd(), rnd()});
        repeat (40) @(negedge clk);
        check(txQ.size() + rxQ.size() + cfgQ.size(), 0);
        $display("drop test done");
        // Memory write payload feeds the configuration port
        dw1 = rnd();
        ad  = rnd();
        send(0, '{32'h40000002, rnd(), rnd(), dw1, ad});
        repeat (20) @(negedge clk);
        check(cfgQ.size(), 2);
        check(cfgQ[0], dw1);
        check(cfgQ[1], ad);
        check(txQ.size(), 0);
        $display("image write test done");
        // Stuck or short patterns must not release the gate
        patMode = 2'd2;
        repeat (30) @(negedge clk);
        patMode = 2'd1;
        repeat (3) @(negedge clk);
        patMode = 2'd0;
        repeat (10) @(negedge clk);
        check(stage2Ready, 0);
        patMode = 2'd1;
        n = 0;
        while (stage2Ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check(n >= CNT && n <= CNT + 4, 1);
        $display("handshake test done after %0d cycles", n);
        // After handoff a read goes to the user with no completion
        rxQ.delete();
        dw1 = rnd();
        ad  = rnd();
        send(0, '{32'h00000001, dw1, ad});
        repeat (30) @(negedge clk);
        check(rxQ.size(), 3);
        if (rxQ.size() == 3) check(rxQ[2], {1'b1, ad});
        check(txQ.size(), 0);
        $display("handoff test done");
        // Fill the transmit buffer against a stalled core, then drain
        stall = 1'b1;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            userTxValid <= (userTxReady === 1'b1);
            userTxWord  <= {1'b0, 32'h0000A000 + 32'(n)};
            if (userTxReady === 1'b1) n++;
        end
        @(negedge clk);
        userTxValid <= 1'b0;
        check(n >= `BSG_FIFO_DEPTH && n < 12, 1);
        stall = 1'b0;
        for (int t = 0; t < 300 && txQ.size() < n; t++) @(negedge clk);
        check(txQ.size(), n);
        for (int i = 0; i < n && txQ.size() > 0; i++)
            check(txQ.pop_front(), {1'b0, 32'h0000A000 + 32'(i)});
        check(userTxReady, 1);
        $display("buffer test done");
        finish_test();
    end
endmodule
`default_nettype wire
